// file: common/fault_seq_pkg.sv
// Shared constants for the charger fault sequencer: timing, widths, input map, states.
// Assumes a single 250 MHz clock; all timing is counted in cycles of it.
package fault_seq_pkg;
   localparam int unsigned CLK_PERIOD_NS = 4;
   // Intervals in their own unit (ns)
   localparam int unsigned BLANK_NS = 10_000_000;
   localparam int unsigned OVP_DGL_NS = 256_000;
   localparam int unsigned OVP_REC_NS = 8_200_000;
   localparam int unsigned OCP_DGL_NS = 176_000;
   localparam int unsigned OCP_REC_NS = 131_000_000;
   localparam int unsigned BOVP_DGL_NS = 8_200_000;
   localparam int unsigned BOVP_REC_NS = 131_000_000;
   localparam int unsigned SOFT_START_NS = 1_000_000;
   localparam int unsigned SOFT_STOP_NS = 100_000;
   // Least times round up, the soft-stop ramp (shortest) rounds down
   localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OVP_DGL_CYC = (OVP_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OVP_REC_CYC = (OVP_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OCP_DGL_CYC = (OCP_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OCP_REC_CYC = (OCP_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BOVP_DGL_CYC = (BOVP_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BOVP_REC_CYC = (BOVP_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SOFT_START_CYC = (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SOFT_STOP_CYC = SOFT_STOP_NS / CLK_PERIOD_NS;
   // Gate drive resolution
   localparam int unsigned GATE_W = 8;
   localparam logic [GATE_W-1:0] GATE_MAX = 8'hFF;
   localparam logic [GATE_W-1:0] GATE_RST = 8'h00;
   localparam int unsigned CNT_W = 26;
   // Comparator input positions in the synchroniser vector
   localparam int unsigned IN_UV_OK = 0;
   localparam int unsigned IN_OVP = 1;
   localparam int unsigned IN_OVP_HYS = 2;
   localparam int unsigned IN_OCP = 3;
   localparam int unsigned IN_BOVP = 4;
   localparam int unsigned IN_BOVP_HYS = 5;
   localparam int unsigned IN_TSD = 6;
   localparam int unsigned IN_TSD_HYS = 7;
   localparam int unsigned IN_SLP_ENT = 8;
   localparam int unsigned IN_SLP_EXIT = 9;
   localparam int unsigned IN_EXT_GATE = 10;
   localparam int unsigned NUM_IN = 11;
   // Interval timer positions
   localparam int unsigned T_BLANK = 0;
   localparam int unsigned T_OVP_DGL = 1;
   localparam int unsigned T_OVP_REC = 2;
   localparam int unsigned T_OCP_DGL = 3;
   localparam int unsigned T_OCP_REC = 4;
   localparam int unsigned T_BOVP_DGL = 5;
   localparam int unsigned T_BOVP_REC = 6;
   localparam int unsigned T_SOFT = 7;
   localparam int unsigned NUM_T = 8;
   typedef enum logic [2:0] {
      S_DOWN = 3'h0,
      S_BLANK = 3'h1,
      S_SOFT = 3'h3,
      S_ON = 3'h2,
      S_STOP = 3'h6,
      S_OFF = 3'h7
   } seq_state_t;
endpackage

// file: common/gate_ramp_if.sv
// Control and status between the sequencer and the protection switch gate ramp.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface gate_ramp_if;
   import fault_seq_pkg::*;
   logic ramp_up;
   logic soft_stop;
   logic hard_off;
   logic [GATE_W-1:0] level;
   logic at_top;
   logic at_bottom;
   modport ctrl(output ramp_up, soft_stop, hard_off, input level, at_top, at_bottom);
   modport ramp(input ramp_up, soft_stop, hard_off, output level, at_top, at_bottom);
endinterface
`default_nettype wire

// file: core/seq_timer.sv
// Interval timer: counts while its condition holds, restarts when it drops.
// Assumes cond and clr are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module seq_timer #(
   parameter int unsigned CW = 26,
   parameter logic [CW-1:0] COUNT = 26'h0000001
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clr,
   input wire logic cond,
   output logic done
);
   logic [CW-1:0] cnt_ff;

   always_ff @(posedge clk) begin
      if (!rstn || clr || !cond) begin
         cnt_ff <= '0;
      end else if (cnt_ff != COUNT) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign done = (cnt_ff == COUNT);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_timer_restart: assert property (!cond |=> cnt_ff == '0)
      else $error("timer did not restart when its condition dropped");
   a_timer_cause: assert property ($rose(done) |-> $past(cond) && !$past(clr))
      else $error("timer expired without its condition");
endmodule // seq_timer
`default_nettype wire

// file: core/gate_ramp.sv
// Protection switch gate drive: stepped soft-start ramp up, soft-stop ramp down, hard off.
// Assumes the controller never asks for up and soft stop together.
`timescale 1ns/1ps
`default_nettype none
module gate_ramp import fault_seq_pkg::*; #(
   parameter int unsigned UP_STEP = 980,
   parameter int unsigned DN_STEP = 98
) (
   input wire logic clk,
   input wire logic rstn,
   gate_ramp_if.ramp rif
);
   logic [CNT_W-1:0] step_ff;
   logic [GATE_W-1:0] level_ff;
   logic moving;
   logic [CNT_W-1:0] step_last;

   assign moving = (rif.ramp_up && level_ff != GATE_MAX) || (rif.soft_stop && level_ff != '0);
   assign step_last = rif.ramp_up ? CNT_W'(UP_STEP - 1) : CNT_W'(DN_STEP - 1);

   always_ff @(posedge clk) begin
      if (!rstn || rif.hard_off || !moving || step_ff == step_last) begin
         step_ff <= '0;
      end else begin
         step_ff <= step_ff + 1'b1;
      end
   end

   // Slow descent keeps the cable inductance from kicking the input up
   always_ff @(posedge clk) begin
      if (!rstn || rif.hard_off) begin
         level_ff <= GATE_RST;
      end else if (moving && step_ff == step_last) begin
         level_ff <= rif.ramp_up ? level_ff + 1'b1 : level_ff - 1'b1;
      end
   end

   assign rif.level = level_ff;
   assign rif.at_top = (level_ff == GATE_MAX);
   assign rif.at_bottom = (level_ff == '0);
endmodule // gate_ramp
`default_nettype wire

// file: core/charger_fault_sequencer.sv
// Charger front-end fault sequencer: power-down, blanking, soft-start, fault trips and recovery.
// Assumes comparator results arrive as levels; they are resynchronised here anyway.
`timescale 1ns/1ps
`default_nettype none
module charger_fault_sequencer import fault_seq_pkg::*; #(
   parameter int unsigned BLANK_CNT = BLANK_CYC,
   parameter int unsigned OVP_DGL_CNT = OVP_DGL_CYC,
   parameter int unsigned OVP_REC_CNT = OVP_REC_CYC,
   parameter int unsigned OCP_DGL_CNT = OCP_DGL_CYC,
   parameter int unsigned OCP_REC_CNT = OCP_REC_CYC,
   parameter int unsigned BOVP_DGL_CNT = BOVP_DGL_CYC,
   parameter int unsigned BOVP_REC_CNT = BOVP_REC_CYC,
   parameter int unsigned SOFT_START_CNT = SOFT_START_CYC,
   parameter int unsigned SOFT_STOP_CNT = SOFT_STOP_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic supply_above_uv,
   input wire logic supply_above_ovp,
   input wire logic supply_below_ovp_hys,
   input wire logic current_above_limit,
   input wire logic battery_above_ovp,
   input wire logic battery_below_ovp_hys,
   input wire logic temp_above_shutdown,
   input wire logic temp_below_hys,
   input wire logic diff_below_sleep_entry,
   input wire logic diff_above_sleep_exit,
   input wire logic external_gate_drive,
   output logic protection_switch_on,
   output logic [GATE_W-1:0] protection_gate_level,
   output logic charge_switch_on,
   output logic current_limit_en,
   output logic sleep_active,
   output logic input_ovp_fault,
   output logic overcurrent_fault,
   output logic battery_ovp_fault,
   output logic thermal_fault
);
   localparam int unsigned UP_STEP_CNT = (SOFT_START_CNT + 254) / 255;
   localparam int unsigned DN_STEP_RAW = SOFT_STOP_CNT / 255;
   localparam int unsigned DN_STEP_CNT = (DN_STEP_RAW < 1) ? 1 : DN_STEP_RAW;
   localparam int unsigned TCNT [NUM_T] = '{
      BLANK_CNT, OVP_DGL_CNT, OVP_REC_CNT, OCP_DGL_CNT,
      OCP_REC_CNT, BOVP_DGL_CNT, BOVP_REC_CNT, SOFT_START_CNT
   };

   logic [NUM_IN-1:0] raw;
   logic [NUM_IN-1:0] meta_ff;
   logic [NUM_IN-1:0] sync_ff;
   logic uv_ok;
   logic [NUM_T-1:0] tcond;
   logic [NUM_T-1:0] tdone;
   seq_state_t state_ff;
   seq_state_t nxt_state;
   logic ovp_trip_ff;
   logic ocp_trip_ff;
   logic bovp_trip_ff;
   logic therm_trip_ff;
   logic sleep_ff;
   logic charge_ff;
   logic nxt_charge;
   logic hard_fault;
   logic soft_fault;
   logic any_trip;
   logic inputs_normal;
   logic powered;
   gate_ramp_if rif ();

   assign raw = {external_gate_drive, diff_above_sleep_exit, diff_below_sleep_entry,
                 temp_below_hys, temp_above_shutdown, battery_below_ovp_hys,
                 battery_above_ovp, current_above_limit, supply_below_ovp_hys,
                 supply_above_ovp, supply_above_uv};

   // Two-stage resync of every comparator; first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_ff <= '0;
      end else begin
         meta_ff <= raw;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sync_ff <= '0;
      end else begin
         sync_ff <= meta_ff;
      end
   end

   assign uv_ok = sync_ff[IN_UV_OK];
   assign powered = (state_ff == S_SOFT) || (state_ff == S_ON);
   assign any_trip = ovp_trip_ff | ocp_trip_ff | bovp_trip_ff | therm_trip_ff;
   assign inputs_normal = !sync_ff[IN_OVP] && !sync_ff[IN_BOVP] && !sync_ff[IN_TSD];
   // Faults that cut the gate at once versus those that ramp it down
   assign hard_fault = ovp_trip_ff | therm_trip_ff | sleep_ff;
   assign soft_fault = ocp_trip_ff | bovp_trip_ff;

   // Interval timer conditions; each restarts if its condition drops early
   always_comb begin
      tcond = '0;
      tcond[T_BLANK] = (state_ff == S_BLANK);
      tcond[T_OVP_DGL] = sync_ff[IN_OVP] && !ovp_trip_ff;
      tcond[T_OVP_REC] = ovp_trip_ff && sync_ff[IN_OVP_HYS];
      tcond[T_OCP_DGL] = sync_ff[IN_OCP] && powered && !ocp_trip_ff;
      tcond[T_OCP_REC] = ocp_trip_ff;
      tcond[T_BOVP_DGL] = sync_ff[IN_BOVP] && !bovp_trip_ff;
      tcond[T_BOVP_REC] = bovp_trip_ff && sync_ff[IN_BOVP_HYS];
      tcond[T_SOFT] = (state_ff == S_SOFT);
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_T; gi++) begin : g_timer
         seq_timer #(
            .CW(CNT_W),
            .COUNT(CNT_W'(TCNT[gi]))
         ) u_timer (
            .clk(clk),
            .rstn(rstn),
            .clr(!uv_ok),
            .cond(tcond[gi]),
            .done(tdone[gi])
         );
      end
   endgenerate

   // Trip latches: a new trip wins over a same-cycle recovery
   always_ff @(posedge clk) begin
      if (!rstn || !uv_ok) begin
         ovp_trip_ff <= 1'b0;
      end else if (tdone[T_OVP_DGL]) begin
         ovp_trip_ff <= 1'b1;
      end else if (tdone[T_OVP_REC]) begin
         ovp_trip_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || !uv_ok) begin
         ocp_trip_ff <= 1'b0;
      end else if (tdone[T_OCP_DGL]) begin
         ocp_trip_ff <= 1'b1;
      end else if (tdone[T_OCP_REC]) begin
         ocp_trip_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || !uv_ok) begin
         bovp_trip_ff <= 1'b0;
      end else if (tdone[T_BOVP_DGL]) begin
         bovp_trip_ff <= 1'b1;
      end else if (tdone[T_BOVP_REC]) begin
         bovp_trip_ff <= 1'b0;
      end
   end

   // Thermal has no deglitch: the comparator has its own hysteresis
   always_ff @(posedge clk) begin
      if (!rstn || !uv_ok) begin
         therm_trip_ff <= 1'b0;
      end else if (sync_ff[IN_TSD]) begin
         therm_trip_ff <= 1'b1;
      end else if (sync_ff[IN_TSD_HYS]) begin
         therm_trip_ff <= 1'b0;
      end
   end

   // Entry and exit come from separate thresholds, so sleep holds in between
   always_ff @(posedge clk) begin
      if (!rstn || !uv_ok) begin
         sleep_ff <= 1'b0;
      end else if (sync_ff[IN_SLP_ENT]) begin
         sleep_ff <= 1'b1;
      end else if (sync_ff[IN_SLP_EXIT]) begin
         sleep_ff <= 1'b0;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_DOWN: begin
            nxt_state = S_BLANK;
         end
         S_BLANK: begin
            if (tdone[T_BLANK]) begin
               nxt_state = S_OFF;
            end
         end
         S_OFF: begin
            if (!any_trip && !sleep_ff && inputs_normal) begin
               nxt_state = S_SOFT;
            end
         end
         S_SOFT: begin
            if (hard_fault) begin
               nxt_state = S_OFF;
            end else if (soft_fault) begin
               nxt_state = S_STOP;
            end else if (tdone[T_SOFT]) begin
               nxt_state = S_ON;
            end
         end
         S_ON: begin
            if (hard_fault) begin
               nxt_state = S_OFF;
            end else if (soft_fault) begin
               nxt_state = S_STOP;
            end
         end
         S_STOP: begin
            if (hard_fault || rif.at_bottom) begin
               nxt_state = S_OFF;
            end
         end
         default: begin
            nxt_state = S_DOWN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn || !uv_ok) begin
         state_ff <= S_DOWN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Gate ramp control
   assign rif.ramp_up = powered && !any_trip && !sleep_ff;
   assign rif.soft_stop = (state_ff == S_STOP);
   assign rif.hard_off = !uv_ok || hard_fault || state_ff == S_DOWN ||
                         state_ff == S_BLANK || state_ff == S_OFF;

   gate_ramp #(
      .UP_STEP(UP_STEP_CNT),
      .DN_STEP(DN_STEP_CNT)
   ) u_ramp (
      .clk(clk),
      .rstn(rstn),
      .rif(rif.ramp)
   );

   // Charge switch follows the host's gate drive only while powered and healthy
   assign nxt_charge = powered && !any_trip && !sleep_ff && uv_ok &&
                       sync_ff[IN_EXT_GATE];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         charge_ff <= 1'b0;
      end else begin
         charge_ff <= nxt_charge;
      end
   end

   assign protection_gate_level = rif.level;
   assign protection_switch_on = !rif.at_bottom;
   assign charge_switch_on = charge_ff;
   // Regulation against the limit is only wanted while the output capacitor charges
   assign current_limit_en = (state_ff == S_SOFT);
   assign sleep_active = sleep_ff;
   assign input_ovp_fault = ovp_trip_ff;
   assign overcurrent_fault = ocp_trip_ff;
   assign battery_ovp_fault = bovp_trip_ff;
   assign thermal_fault = therm_trip_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_down_all_off: assert property (!uv_ok |=> !protection_switch_on && !charge_switch_on)
      else $error("switch on while supply below under-voltage");
   a_uv_restart: assert property ($rose(uv_ok) |=> state_ff == S_BLANK && !any_trip)
      else $error("power-on did not start from a clean blanking state");
   a_blank_needs_ok: assert property ($rose(state_ff == S_SOFT) |-> $past(inputs_normal)
                                     && !$past(any_trip))
      else $error("soft-start begun with abnormal supply or battery");
   a_blank_timed: assert property ($fell(state_ff == S_BLANK) && uv_ok |->
                                  $past(tdone[T_BLANK]))
      else $error("blanking ended before its interval");
   a_limit_soft_only: assert property (state_ff == S_ON |-> !current_limit_en)
      else $error("current limit active after soft-start");
   a_ocp_cut: assert property (tdone[T_OCP_DGL] && uv_ok |-> ##2 !charge_switch_on)
      else $error("charge switch still on after overcurrent deglitch");
   a_stop_ramps_down: assert property (state_ff == S_STOP |=>
                                       protection_gate_level <= $past(protection_gate_level))
      else $error("gate rose during soft-stop");
   // Recovery may end before the ramp does, so check the whole trip span, not only OFF
   a_ocp_hold_off: assert property (ocp_trip_ff |=> !charge_switch_on && !powered)
      else $error("switch on during overcurrent recovery");
   a_short_soft_stop: assert property (state_ff == S_SOFT && soft_fault && !hard_fault |=>
                                       state_ff == S_STOP)
      else $error("short circuit at power-on not soft-stopped");
   a_sleep_off: assert property (sleep_ff |=>
                                 protection_gate_level == '0 && !charge_switch_on)
      else $error("switch on while asleep");
   a_sleep_hys: assert property (sleep_ff && !sync_ff[IN_SLP_EXIT] && uv_ok |=> sleep_ff)
      else $error("sleep left without exit threshold");
   a_ovp_cut: assert property (tdone[T_OVP_DGL] && uv_ok |-> ##2
                               (protection_gate_level == '0 && !charge_switch_on))
      else $error("switches on after input over-voltage deglitch");
   a_ovp_recover: assert property ($fell(ovp_trip_ff) && uv_ok |-> $past(tdone[T_OVP_REC]))
      else $error("over-voltage trip cleared without recovery interval");
   a_bovp_cut: assert property (tdone[T_BOVP_DGL] && uv_ok |-> ##2 !charge_switch_on)
      else $error("charge switch on after battery over-voltage deglitch");
   a_bovp_recover: assert property ($fell(bovp_trip_ff) && uv_ok |->
                                   $past(tdone[T_BOVP_REC]))
      else $error("battery trip cleared too early");
   a_bovp_ramps: assert property (state_ff == S_ON && bovp_trip_ff && !hard_fault |=>
                                  state_ff == S_STOP)
      else $error("battery over-voltage not soft-stopped");
   a_therm_cut: assert property (sync_ff[IN_TSD] && uv_ok |-> ##2
                                 (protection_gate_level == '0 && !charge_switch_on))
      else $error("switches on while over temperature");

   c_reach_on: cover property (state_ff == S_SOFT ##1 state_ff == S_ON);
   c_ocp_stop: cover property (state_ff == S_STOP ##1 state_ff == S_OFF);
   c_sleep: cover property ($rose(sleep_ff));
   c_ovp_recover: cover property ($fell(ovp_trip_ff));
endmodule // charger_fault_sequencer
`default_nettype wire

// file: test/adapter_model.sv
// Adapter, charger and battery model: turns levels into comparator results.
// Assumes the bench sets millivolts, milliamps and degrees; out_mv never above supply_mv.
`timescale 1ns/1ps
`default_nettype none
module adapter_model import fault_seq_pkg::*; #(
   parameter int unsigned UV_MV = 2500,
   parameter int unsigned OVP_MV = 10500,
   parameter int unsigned OVP_HYS_MV = 160,
   parameter int unsigned OCP_MA = 1200,
   parameter int unsigned BOVP_MV = 4350,
   parameter int unsigned BHYS_MV = 250,
   parameter int unsigned TSD_C = 150,
   parameter int unsigned THYS_C = 20,
   parameter int unsigned SENTRY_MV = 55,
   parameter int unsigned SEXIT_MV = 90
) (
   input wire logic [15:0] supply_mv,
   input wire logic [15:0] load_ma,
   input wire logic [15:0] bat_mv,
   input wire logic [15:0] temp_c,
   input wire logic [15:0] out_mv,
   output logic [IN_SLP_EXIT:0] cmp
);
   logic [15:0] diff_mv;
   assign diff_mv = supply_mv - out_mv;
   assign cmp[IN_UV_OK] = supply_mv > UV_MV;
   assign cmp[IN_OVP] = supply_mv > OVP_MV;
   assign cmp[IN_OVP_HYS] = supply_mv < OVP_MV - OVP_HYS_MV;
   assign cmp[IN_OCP] = load_ma > OCP_MA;
   assign cmp[IN_BOVP] = bat_mv > BOVP_MV;
   assign cmp[IN_BOVP_HYS] = bat_mv < BOVP_MV - BHYS_MV;
   assign cmp[IN_TSD] = temp_c > TSD_C;
   assign cmp[IN_TSD_HYS] = temp_c < TSD_C - THYS_C;
   // Exit above entry gives the sleep hysteresis
   assign cmp[IN_SLP_ENT] = diff_mv < SENTRY_MV;
   assign cmp[IN_SLP_EXIT] = diff_mv > SEXIT_MV;
endmodule // adapter_model
`default_nettype wire

// file: test/charger_fault_sequencer_tb.sv
// Self-checking bench for the charger fault sequencer, with shortened intervals.
// Assumes adapter_model supplies the comparator levels.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) check(n, 8'(e), 8'(g))
module charger_fault_sequencer_tb;
   import fault_seq_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ext_gate = 1'b1;
   logic [15:0] supply_mv = 16'h0000;
   logic [15:0] load_ma = 16'h01F4;
   logic [15:0] bat_mv = 16'h0ED8;
   logic [15:0] temp_c = 16'h0019;
   logic [15:0] out_mv = 16'h0000;
   logic [IN_SLP_EXIT:0] cmp;
   logic [GATE_W-1:0] gate;
   logic psw, csw, lim, slp, f_ovp, f_ocp, f_bovp, f_th;
   int mismatches = 0;
   int n_compared = 0;
   always #2 clk = ~clk;
   adapter_model adapter_model_i (.supply_mv(supply_mv), .load_ma(load_ma), .bat_mv(bat_mv),
      .temp_c(temp_c), .out_mv(out_mv), .cmp(cmp));
   charger_fault_sequencer #(.BLANK_CNT(20), .OVP_DGL_CNT(5), .OVP_REC_CNT(10), .OCP_DGL_CNT(5),
      .OCP_REC_CNT(30), .BOVP_DGL_CNT(8), .BOVP_REC_CNT(30), .SOFT_START_CNT(300),
      .SOFT_STOP_CNT(60)) charger_fault_sequencer_i (.clk(clk), .rstn(rstn),
      .supply_above_uv(cmp[IN_UV_OK]), .supply_above_ovp(cmp[IN_OVP]),
      .supply_below_ovp_hys(cmp[IN_OVP_HYS]), .current_above_limit(cmp[IN_OCP]),
      .battery_above_ovp(cmp[IN_BOVP]), .battery_below_ovp_hys(cmp[IN_BOVP_HYS]),
      .temp_above_shutdown(cmp[IN_TSD]), .temp_below_hys(cmp[IN_TSD_HYS]),
      .diff_below_sleep_entry(cmp[IN_SLP_ENT]), .diff_above_sleep_exit(cmp[IN_SLP_EXIT]),
      .external_gate_drive(ext_gate), .protection_switch_on(psw), .protection_gate_level(gate),
      .charge_switch_on(csw), .current_limit_en(lim), .sleep_active(slp),
      .input_ovp_fault(f_ovp), .overcurrent_fault(f_ocp), .battery_ovp_fault(f_bovp),
      .thermal_fault(f_th));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (e !== g) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Supply drop clears any latched trip, then a fresh blanking and, when on is set, soft-start
   task automatic power_on(input logic [15:0] bat, input logic on);
      bat_mv = bat;
      supply_mv = 16'h0000;
      step(4);
      `CHK("psw off", 1'b0, psw);
      `CHK("csw off", 1'b0, csw);
      `CHK("bovp cleared", 1'b0, f_bovp);
      supply_mv = 16'h1388;
      step(15);
      `CHK("blank gate", 8'h00, gate);
      step(25);
      `CHK("soft limit", on, lim);
      `CHK("psw soft", on, psw);
      if (on) begin
         // The ramp takes two cycles a step here, so it finishes well after soft-start
         step(500);
         `CHK("limit end", 1'b0, lim);
         `CHK("gate full", GATE_MAX, gate);
         `CHK("csw on", 1'b1, csw);
         ext_gate = 1'b0;
         step(3);
         `CHK("csw host off", 1'b0, csw);
         ext_gate = 1'b1;
         step(3);
         `CHK("csw host on", 1'b1, csw);
      end
   endtask
   task automatic overcurrent;
      load_ma = 16'h05DC;
      step(5);
      `CHK("ocp early", 1'b0, f_ocp);
      step(5);
      `CHK("ocp trip", 1'b1, f_ocp);
      `CHK("ocp csw", 1'b0, csw);
      `CHK("ocp ramping", 1'b1, psw && gate < GATE_MAX);
      load_ma = 16'h01F4;
      step(400);
      `CHK("ocp clear", 1'b0, f_ocp);
      `CHK("ocp resoft", 1'b1, lim);
      step(300);
      `CHK("ocp back", 1'b1, psw);
   endtask
   task automatic input_ovp;
      supply_mv = 16'h2AF8;
      step(4);
      `CHK("ovp early", 1'b0, f_ovp);
      step(8);
      `CHK("ovp trip", 1'b1, f_ovp);
      `CHK("ovp gate", 8'h00, gate);
      `CHK("ovp csw", 1'b0, csw);
      supply_mv = 16'h1388;
      step(8);
      `CHK("ovp hold", 1'b1, f_ovp);
      step(12);
      `CHK("ovp clear", 1'b0, f_ovp);
      `CHK("ovp resoft", 1'b1, lim);
      step(320);
   endtask
   task automatic battery_ovp;
      bat_mv = 16'h1130;
      step(6);
      `CHK("bovp early", 1'b0, f_bovp);
      step(8);
      `CHK("bovp trip", 1'b1, f_bovp);
      `CHK("bovp csw", 1'b0, csw);
      `CHK("bovp ramp", 1'b1, psw);
      bat_mv = 16'h0ED8;
      step(20);
      bat_mv = 16'h1068;
      step(2);
      bat_mv = 16'h0ED8;
      step(20);
      `CHK("bovp restart", 1'b1, f_bovp);
      step(20);
      `CHK("bovp clear", 1'b0, f_bovp);
      step(600);
      `CHK("bovp back", 1'b1, psw);
   endtask
   task automatic thermal;
      temp_c = 16'h00A0;
      step(6);
      `CHK("tsd trip", 1'b1, f_th);
      `CHK("tsd gate", 8'h00, gate);
      temp_c = 16'h008C;
      step(10);
      `CHK("tsd hys", 1'b1, f_th);
      temp_c = 16'h0019;
      step(6);
      `CHK("tsd clear", 1'b0, f_th);
   endtask
   task automatic sleep_mode;
      out_mv = 16'h136A;
      step(6);
      `CHK("sleep in", 1'b1, slp);
      `CHK("sleep csw", 1'b0, csw);
      `CHK("sleep gate", 8'h00, gate);
      out_mv = 16'h1342;
      step(6);
      `CHK("sleep hys", 1'b1, slp);
      out_mv = 16'h0FA0;
      step(6);
      `CHK("sleep out", 1'b0, slp);
   endtask
   initial begin
      step(5);
      rstn = 1'b1;
      out_mv = 16'h0FA0;
      power_on(16'h0ED8, 1'b1);
      overcurrent();
      input_ovp();
      battery_ovp();
      thermal();
      sleep_mode();
      bat_mv = 16'h1130;
      step(14);
      power_on(16'h1130, 1'b0);
      conclude();
   end
   // Whole run needs about 2400 cycles
   initial begin
      #(10000 * 4);
      mismatches++;
      conclude();
   end
endmodule // charger_fault_sequencer_tb
`default_nettype wire
